// ==== common/branch_spec_consts.vh ====
`ifndef BRANCH_SPEC_CONSTS_VH
`define BRANCH_SPEC_CONSTS_VH

// Address and table geometry
`define ADDR_W          32
`define TPB_ENTRIES     16
`define TPB_IDX_W       4
`define RAS_DEPTH       8
`define RAS_PTR_W       3

// Speculation limits
`define SPEC_LVL_W      3
`define SPEC_LVL_MAX    3'h4
`define FPU_Q_DEPTH     3'h4
`define WBUF_DEPTH      3'h4

// Redirect penalties in cycles
`define PEN_EXEC        3'h4
`define PEN_WB          3'h5

// Two-bit history counter states
`define HIST_STRONG_NT  2'h0
`define HIST_WEAK_NT    2'h1
`define HIST_WEAK_T     2'h2
`define HIST_STRONG_T   2'h3
`define HIST_RESET      2'h1

// Instruction length used for sequential fetch
`define INSN_STEP       32'h00000004

`endif

// ==== core/branch_speculation_control.v ====
`timescale 1ns/1ps
`include "branch_spec_consts.vh"

module branch_speculation_control (
	// Clock and reset
	input  wire                    sys_clk_i,
	input  wire                    reset_i,
	// Prefetch side
	input  wire                    pf_valid_i,
	input  wire [`ADDR_W-1:0]      pf_pc_i,
	input  wire                    pf_is_branch_i,
	input  wire                    pf_is_cond_i,
	input  wire                    pf_is_call_i,
	input  wire                    pf_is_ret_i,
	output reg  [`ADDR_W-1:0]      fetch_addr_o,
	output reg                     fetch_taken_o,
	output reg                     fetch_valid_o,
	// Decode and issue
	input  wire                    dec_branch_i,
	input  wire                    dec_fp_i,
	output wire                    issue_primary_o,
	output wire                    issue_secondary_ok_o,
	// Branch resolution
	input  wire                    res_valid_i,
	input  wire                    res_cc_parallel_i,
	input  wire                    res_taken_i,
	input  wire                    res_pred_taken_i,
	input  wire [`ADDR_W-1:0]      res_pc_i,
	input  wire [`ADDR_W-1:0]      res_target_i,
	// Pipeline redirect
	output reg                     flush_o,
	output reg                     restore_o,
	output reg  [`ADDR_W-1:0]      redirect_addr_o,
	output reg                     stall_o,
	output reg                     feed_first_decode_o,
	// Second address stage and floating unit
	input  wire                    fp_addr_ok_i,
	input  wire                    fp_complete_i,
	output reg                     fp_enqueue_o,
	output reg  [2:0]              fp_queue_count_o,
	// Speculation control
	input  wire                    exception_i,
	input  wire                    sys_modify_i,
	output reg                     checkpoint_o,
	output reg                     release_o,
	output reg  [`SPEC_LVL_W-1:0]  spec_level_o,
	output wire                    spec_halt_o,
	// Write path
	input  wire                    wr_req_i,
	input  wire [`ADDR_W-1:0]      wr_addr_i,
	input  wire                    wr_drain_ready_i,
	output wire                    wr_accept_o,
	output reg                     wr_valid_o,
	output reg  [`ADDR_W-1:0]      wr_addr_o,
	output reg                     exc_signal_o
);

	// ****************************************************************
	// Target prediction buffer and return address stack
	// ****************************************************************
	reg [`ADDR_W-1:0]     tpb_tag [0:`TPB_ENTRIES-1];
	reg [`ADDR_W-1:0]     tpb_tgt [0:`TPB_ENTRIES-1];
	reg [1:0]             tpb_hist [0:`TPB_ENTRIES-1];
	reg                   tpb_vld [0:`TPB_ENTRIES-1];
	reg [`ADDR_W-1:0]     ras [0:`RAS_DEPTH-1];
	reg [`RAS_PTR_W-1:0]  ras_ptr;
	reg [`RAS_PTR_W:0]    ras_cnt;

	wire [`TPB_IDX_W-1:0] pf_idx = pf_pc_i[`TPB_IDX_W+1:2];
	wire [`TPB_IDX_W-1:0] rs_idx = res_pc_i[`TPB_IDX_W+1:2];
	wire                  pf_hit = tpb_vld[pf_idx] && (tpb_tag[pf_idx] == pf_pc_i);
	wire [`ADDR_W-1:0]    seq_pc = pf_pc_i + `INSN_STEP;
	wire [`RAS_PTR_W-1:0] ras_top = ras_ptr - 3'h1;
	wire                  ras_hit = (ras_cnt != 4'h0);

	// ****************************************************************
	// Speculation state
	// ****************************************************************
	reg  [2:0]            pen_cnt;
	reg  [2:0]            wbuf_cnt;
	reg  [`ADDR_W-1:0]    wbuf_addr [0:3];
	reg  [1:0]            wbuf_rd;
	reg  [1:0]            wbuf_wr;
	reg  [3:0]            wbuf_spec;
	reg  [3:0]            wbuf_kill;
	reg  [`SPEC_LVL_W-1:0] next_spec_level;
	reg                   exc_pending;

	wire mispredict = res_valid_i && (res_taken_i != res_pred_taken_i);
	wire correct    = res_valid_i && !mispredict;
	wire level_full = (spec_level_o == `SPEC_LVL_MAX);
	wire wbuf_full  = (wbuf_cnt == `WBUF_DEPTH);
	wire fpq_full   = (fp_queue_count_o == `FPU_Q_DEPTH);

	// ****************************************************************
	// Speculation halt causes
	// ****************************************************************
	// Any one of the four causes stops new levels from opening; closing still lowers the counter
	wire halt_level = (dec_branch_i || dec_fp_i) && level_full;
	wire halt_fault = exception_i;
	wire halt_wbuf  = wbuf_full;
	wire halt_sys   = sys_modify_i;

	assign spec_halt_o = halt_level || halt_fault || halt_wbuf || halt_sys;
	assign issue_primary_o      = dec_branch_i || dec_fp_i;
	assign issue_secondary_ok_o = !(dec_branch_i || dec_fp_i);

	// ****************************************************************
	// Speculation entry and exit
	// ****************************************************************
	// A new level needs a free slot, no redirect in flight and no halt
	wire no_penalty = (pen_cnt == 3'h0);
	wire level_room = !level_full;
	wire pf_cond    = pf_valid_i && pf_is_branch_i && pf_is_cond_i;
	wire fp_room    = !fpq_full;

	// Conditional branch predicted at prefetch opens a level
	wire pf_cond_pred = pf_cond && no_penalty && level_room && !spec_halt_o;
	// Float op that passed its address checks opens a level
	wire fp_take = fp_addr_ok_i && fp_room && level_room && !spec_halt_o && no_penalty;
	wire inc = pf_cond_pred || fp_take;
	// A resolved branch or finished float op closes a level; both in one clock close just one
	wire dec = res_valid_i || fp_complete_i;

	// ****************************************************************
	// Level counter
	// ****************************************************************
	// Level counter: saturates at zero and four
	always @* begin
		next_spec_level = spec_level_o;
		case ({inc, dec})
			2'b10: begin
				if (!level_full)
					next_spec_level = spec_level_o + 3'h1;
			end
			2'b01: begin
				if (spec_level_o != 3'h0)
					next_spec_level = spec_level_o - 3'h1;
			end
			// Open and close in one clock cancel out
			default: next_spec_level = spec_level_o;
		endcase
	end

	// ****************************************************************
	// Prediction and fetch
	// ****************************************************************
	integer i;
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			for (i = 0; i < `TPB_ENTRIES; i = i + 1) begin
				tpb_vld[i]  <= 1'b0;
				tpb_hist[i] <= `HIST_RESET;
				tpb_tag[i]  <= 32'h00000000;
				tpb_tgt[i]  <= 32'h00000000;
			end
			ras_ptr       <= 3'h0;
			ras_cnt       <= 4'h0;
			fetch_addr_o  <= 32'h00000000;
			fetch_taken_o <= 1'b0;
			fetch_valid_o <= 1'b0;
		end else begin
			fetch_valid_o <= pf_valid_i && (pen_cnt == 3'h0);
			fetch_taken_o <= 1'b0;
			fetch_addr_o  <= seq_pc;
			if (pf_valid_i && pf_is_ret_i && ras_hit) begin
				fetch_addr_o  <= ras[ras_top];
				fetch_taken_o <= 1'b1;
				ras_ptr       <= ras_top;
				ras_cnt       <= ras_cnt - 4'h1;
			end else if (pf_valid_i && pf_is_branch_i && pf_hit) begin
				if (!pf_is_cond_i) begin
					fetch_addr_o  <= tpb_tgt[pf_idx];
					fetch_taken_o <= 1'b1;
				end else if (tpb_hist[pf_idx][1]) begin
					fetch_addr_o  <= tpb_tgt[pf_idx];
					fetch_taken_o <= 1'b1;
				end
			end
			// Conditional miss keeps seq_pc, not taken
			if (pf_valid_i && pf_is_call_i) begin
				ras[ras_ptr] <= seq_pc;
				ras_ptr      <= ras_ptr + 3'h1;
				if (ras_cnt != 4'h8)
					ras_cnt <= ras_cnt + 4'h1;
			end
			if (res_valid_i) begin
				tpb_vld[rs_idx] <= 1'b1;
				tpb_tag[rs_idx] <= res_pc_i;
				if (res_taken_i)
					tpb_tgt[rs_idx] <= res_target_i;
				if (res_taken_i && tpb_hist[rs_idx] != `HIST_STRONG_T)
					tpb_hist[rs_idx] <= tpb_hist[rs_idx] + 2'h1;
				else if (!res_taken_i && tpb_hist[rs_idx] != `HIST_STRONG_NT)
					tpb_hist[rs_idx] <= tpb_hist[rs_idx] - 2'h1;
			end
		end
	end

	// ****************************************************************
	// Resolution, redirect and checkpoints
	// ****************************************************************
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			pen_cnt             <= 3'h0;
			flush_o             <= 1'b0;
			restore_o           <= 1'b0;
			redirect_addr_o     <= 32'h00000000;
			stall_o             <= 1'b0;
			feed_first_decode_o <= 1'b0;
			checkpoint_o        <= 1'b0;
			release_o           <= 1'b0;
			spec_level_o        <= 3'h0;
			fp_enqueue_o        <= 1'b0;
			fp_queue_count_o    <= 3'h0;
		end else begin
			checkpoint_o <= inc;
			release_o    <= correct || fp_complete_i;
			fp_enqueue_o <= fp_take;
			flush_o      <= mispredict;
			restore_o    <= mispredict;
			feed_first_decode_o <= 1'b0;
			if (mispredict) begin
				spec_level_o    <= 3'h0;
				redirect_addr_o <= res_taken_i ? res_target_i : res_pc_i + `INSN_STEP;
				// Penalty counts the cycles still to wait after this one
				pen_cnt <= (res_cc_parallel_i ? `PEN_WB : `PEN_EXEC) - 3'h1;
				stall_o <= 1'b1;
			end else begin
				spec_level_o <= next_spec_level;
				if (pen_cnt != 3'h0) begin
					pen_cnt <= pen_cnt - 3'h1;
					if (pen_cnt == 3'h1) begin
						stall_o             <= 1'b0;
						feed_first_decode_o <= 1'b1;
					end
				end
			end
			if (fp_take && !fp_complete_i)
				fp_queue_count_o <= fp_queue_count_o + 3'h1;
			else if (fp_complete_i && !fp_take && fp_queue_count_o != 3'h0)
				fp_queue_count_o <= fp_queue_count_o - 3'h1;
		end
	end

	// ****************************************************************
	// Write buffers, held while speculative, drained in order
	// ****************************************************************
	assign wr_accept_o = !wbuf_full;

	wire head_spec  = wbuf_spec[wbuf_rd];
	wire head_kill  = wbuf_kill[wbuf_rd];
	wire drain      = (wbuf_cnt != 3'h0) && !head_spec && wr_drain_ready_i && !exc_pending;
	wire push       = wr_req_i && !wbuf_full;

	// Entries are cleared once no unresolved level governs them
	wire level_zero   = (spec_level_o == 3'h0);
	wire last_resolve = (correct || fp_complete_i) && (spec_level_o == 3'h1);
	wire clear_spec   = level_zero || last_resolve;

	// ****************************************************************
	// Write buffer entries
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_wbuf
			always @(posedge sys_clk_i) begin
				if (reset_i) begin
					wbuf_spec[g] <= 1'b0;
					wbuf_kill[g] <= 1'b0;
					wbuf_addr[g] <= 32'h00000000;
				end else if (push && wbuf_wr == g) begin
					wbuf_addr[g] <= wr_addr_i;
					// A write racing a mispredict belongs to the wrong path
					wbuf_kill[g] <= mispredict && (spec_level_o != 3'h0);
					wbuf_spec[g] <= (spec_level_o != 3'h0) && !mispredict;
				end else if (mispredict && wbuf_spec[g]) begin
					// Wrong-path writes are dropped, never issued
					wbuf_kill[g] <= 1'b1;
					wbuf_spec[g] <= 1'b0;
				end else if (clear_spec) begin
					wbuf_spec[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Buffer pointers and exception ordering
	// ****************************************************************
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			wbuf_rd      <= 2'h0;
			wbuf_wr      <= 2'h0;
			wbuf_cnt     <= 3'h0;
			wr_valid_o   <= 1'b0;
			wr_addr_o    <= 32'h00000000;
			exc_pending  <= 1'b0;
			exc_signal_o <= 1'b0;
		end else begin
			wr_valid_o   <= drain && !head_kill;
			exc_signal_o <= 1'b0;
			if (drain) begin
				wr_addr_o <= wbuf_addr[wbuf_rd];
				wbuf_rd   <= wbuf_rd + 2'h1;
			end
			if (push)
				wbuf_wr <= wbuf_wr + 2'h1;
			if (push && !drain)
				wbuf_cnt <= wbuf_cnt + 3'h1;
			else if (drain && !push)
				wbuf_cnt <= wbuf_cnt - 3'h1;
			// Exception waits for the write buffer to be empty; the drain is stopped while it waits
			if (exception_i)
				exc_pending <= 1'b1;
			else if (exc_pending && wbuf_cnt == 3'h0) begin
				exc_pending  <= 1'b0;
				exc_signal_o <= 1'b1;
			end
		end
	end

endmodule // branch_speculation_control

// ==== verif/branch_spec_asserts.sv ====
`timescale 1ns/1ps
`include "branch_spec_consts.vh"
module branch_spec_asserts (
	input wire sys_clk_i, reset_i, dec_branch_i, dec_fp_i, issue_primary_o,
	input wire issue_secondary_ok_o, res_valid_i, res_cc_parallel_i, res_taken_i,
	input wire res_pred_taken_i, flush_o, restore_o, stall_o, feed_first_decode_o,
	input wire release_o, fp_enqueue_o, checkpoint_o, exception_i, sys_modify_i,
	input wire spec_halt_o, pf_valid_i, pf_is_branch_i, pf_is_ret_i, fetch_valid_o,
	input wire [`SPEC_LVL_W-1:0] spec_level_o,
	input wire [2:0]             fp_queue_count_o,
	input wire [`ADDR_W-1:0]     pf_pc_i,
	input wire [`ADDR_W-1:0]     fetch_addr_o
);
	// ********
	// Checks
	// ********
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	wire miss = res_valid_i && (res_taken_i != res_pred_taken_i);
	wire top  = spec_level_o == `SPEC_LVL_MAX;
	a_branch_primary: assert property (
		dec_branch_i |-> issue_primary_o && !issue_secondary_ok_o) else $error("branch pipe");
	a_level_bound: assert property (spec_level_o <= `SPEC_LVL_MAX)
		else $error("level above four");
	a_miss_restore: assert property (
		miss |=> flush_o && restore_o && spec_level_o == 0) else $error("no restore");
	a_exec_penalty: assert property (
		miss && !res_cc_parallel_i |=> stall_o [*3] ##1 feed_first_decode_o && !stall_o)
		else $error("execute penalty");
	a_wb_penalty: assert property (
		miss && res_cc_parallel_i |=> stall_o [*4] ##1 feed_first_decode_o && !stall_o)
		else $error("writeback penalty");
	a_hit_release: assert property (res_valid_i && !miss |=> release_o)
		else $error("no release");
	a_fp_checkpoint: assert property (fp_enqueue_o |-> checkpoint_o)
		else $error("enqueue without checkpoint");
	a_fpq_bound: assert property (fp_queue_count_o <= `FPU_Q_DEPTH)
		else $error("queue above four");
	a_halt_cause: assert property (
		exception_i || sys_modify_i || top && (dec_branch_i || dec_fp_i) |-> spec_halt_o)
		else $error("no halt");
	a_seq_fetch: assert property (
		pf_valid_i && !pf_is_branch_i && !pf_is_ret_i && !stall_o
		|=> !fetch_valid_o || fetch_addr_o == $past(pf_pc_i) + `INSN_STEP)
		else $error("sequential fetch");
endmodule // branch_spec_asserts
bind branch_speculation_control branch_spec_asserts u_asserts (.*);

// ==== verif/fpu_partner.sv ====
`timescale 1ns/1ps
module fpu_partner (
	input  wire  clk_i,
	input  wire  reset_i,
	input  wire  enq_i,
	input  wire  slow_i,
	output logic done_o = 1'b0,
	output logic ready_o = 1'b1
);
	int pend = 0;
	int cnt = 0;
	// Slow mode completes rarely and stalls the write drain at random
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		ready_o <= !slow_i || $urandom_range(1);
		pend = reset_i ? 0 : pend + enq_i;
		cnt = pend > 0 ? cnt + 1 : 0;
		if (cnt >= (slow_i ? 12 : 2)) begin
			done_o <= 1'b1;
			pend--;
			cnt = 0;
		end
	end
endmodule // fpu_partner

// ==== verif/branch_speculation_control_tb.sv ====
`timescale 1ns/1ps
`include "branch_spec_consts.vh"
module branch_speculation_control_tb;
	// ********
	// Harness
	// ********
	logic sys_clk_i = 0, reset_i = 1, slow = 0, pf_valid_i = 0, pf_is_branch_i = 0;
	logic pf_is_cond_i = 0, pf_is_call_i = 0, pf_is_ret_i = 0, dec_branch_i = 0;
	logic dec_fp_i = 0, res_valid_i = 0, res_cc_parallel_i = 0, res_taken_i = 0;
	logic res_pred_taken_i = 0, fp_addr_ok_i = 0, exception_i = 0, sys_modify_i = 0;
	logic wr_req_i = 0, fp_complete_i, wr_drain_ready_i, d;
	logic [31:0] pf_pc_i = 0, res_pc_i = 0, res_target_i = 0, wr_addr_i = 0, a;
	wire [31:0] fetch_addr_o, redirect_addr_o, wr_addr_o;
	wire [2:0] fp_queue_count_o, spec_level_o;
	wire fetch_taken_o, fetch_valid_o, issue_primary_o, issue_secondary_ok_o, flush_o;
	wire restore_o, stall_o, feed_first_decode_o, fp_enqueue_o, checkpoint_o, release_o;
	wire spec_halt_o, wr_accept_o, wr_valid_o, exc_signal_o;
	int fails = 0, check_count = 0, lvl = 0, n;
	realtime t_pf = -1, t_res = -1;
	logic [31:0] q[$];
	branch_speculation_control u_dut (.*);
	fpu_partner u_fpu (.clk_i(sys_clk_i), .reset_i(reset_i), .enq_i(fp_enqueue_o),
		.slow_i(slow), .done_o(fp_complete_i), .ready_o(wr_drain_ready_i));
	initial forever #2 sys_clk_i = !sys_clk_i;
	task automatic conclude();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic tick(input int k = 1);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic pf(input logic [31:0] pc, input logic [3:0] f);
		if ($realtime == t_pf)
			tick();
		{pf_is_branch_i, pf_is_cond_i, pf_is_call_i, pf_is_ret_i} = f;
		pf_pc_i = pc;
		pf_valid_i = 1;
		tick();
		pf_valid_i = 0;
		t_pf = $realtime;
	endtask
	task automatic res(input logic [31:0] pc, t, input logic tk, ptk, par);
		if ($realtime == t_res)
			tick();
		{res_pc_i, res_target_i} = {pc, t};
		{res_taken_i, res_pred_taken_i, res_cc_parallel_i, res_valid_i} = {tk, ptk, par, 1'b1};
		tick();
		res_valid_i = 0;
		t_res = $realtime;
	endtask
	task automatic hit(input logic inc);
		res(0, 0, 0, 0, 0);
		if (!inc && lvl > 0)
			lvl--;
		chk("release", release_o, 1);
		chk("level", spec_level_o, lvl);
	endtask
	task automatic miss(input logic [31:0] pc, t, input logic tk, par);
		res(pc, t, tk, !tk, par);
		lvl = 0;
		chk("flush", {flush_o, restore_o, stall_o}, 3'h7);
		chk("redirect", redirect_addr_o, tk ? t : pc + 4);
		chk("level", spec_level_o, 0);
		for (n = 1; n < 9 && feed_first_decode_o !== 1'b1; n++)
			tick();
		chk("penalty", n, par ? 5 : 4);
	endtask
	initial begin
		#20000;
		fails++;
		conclude();
	end
	initial begin
		void'($urandom(32'h7dbe));
		tick(5);
		reset_i = 0;
		chk("level", spec_level_o, 0);
		for (int i = 0; i < 6; i++) begin
			a = $urandom & 32'hfffffffc;
			pf(a, i > 0 ? 4'hc : 4'h0);
			chk("seq", fetch_addr_o, a + 4);
			chk("taken", fetch_taken_o, 0);
			if (i > 0) begin
				chk("ckpt", checkpoint_o, lvl < 4);
				if (lvl < 4)
					lvl++;
			end
			chk("level", spec_level_o, lvl);
		end
		for (int i = 0; i < 4; i++) begin
			{dec_fp_i, dec_branch_i, exception_i, sys_modify_i} = 4'h8 >> i;
			#0.5;
			chk("halt", spec_halt_o, 1);
			chk("pipe", issue_secondary_ok_o, !(dec_branch_i || dec_fp_i));
			chk("primary", issue_primary_o, dec_branch_i || dec_fp_i);
			tick();
			chk("exception", exc_signal_o, i == 3);
		end
		sys_modify_i = 0;
		hit(0);
		tick();
		{pf_valid_i, pf_is_branch_i, pf_is_cond_i, pf_pc_i} = {3'h7, 32'h1c0};
		hit(1);
		pf_valid_i = 0;
		for (int i = 0; i < 5; i++) begin
			wr_addr_i = $urandom;
			wr_req_i = 1;
			#0.5;
			chk("accept", wr_accept_o, i < 4);
			if (i < 4)
				q.push_back(wr_addr_i);
			tick();
			chk("held", wr_valid_o, 0);
		end
		wr_req_i = 0;
		slow = 1;
		repeat (3)
			hit(0);
		for (n = 0; n < 80 && q.size() > 0; n++) begin
			if (wr_valid_o)
				chk("write", wr_addr_o, q.pop_front());
			tick();
		end
		chk("drained", q.size(), 0);
		for (int j = 0; j < 2; j++) begin
			miss(32'h104, 32'h2000, !j, j);
			pf(32'h104, 4'hc);
			lvl++;
			chk("predict", fetch_addr_o, j ? 32'h108 : 32'h2000);
			chk("taken", fetch_taken_o, !j);
		end
		miss(32'h148, 32'h3000, 1, 0);
		pf(32'h148, 4'h8);
		chk("target", fetch_addr_o, 32'h3000);
		for (int i = 0; i < 4; i++) begin
			a = i < 2 ? 32'h300 + 64 * i : $urandom & 32'hfffffffc;
			pf(a, i < 2 ? 4'ha : 4'h9);
			if (i < 2)
				q.push_back(a + 4);
			else begin
				chk("return", fetch_addr_o, q.pop_back());
				chk("one clock", fetch_valid_o, 1);
			end
		end
		for (int i = 0; i < 60; i++) begin
			fp_addr_ok_i = i < 8;
			d = fp_complete_i;
			tick();
			lvl = lvl + fp_enqueue_o - d;
			chk("level", spec_level_o, lvl);
			if (i == 7)
				chk("queue", fp_queue_count_o, 4);
		end
		chk("empty", fp_queue_count_o, 0);
		conclude();
	end
endmodule // branch_speculation_control_tb
